// >>> hw/dbgrom_table.sv
// module: read-only debug rom table, one 4KB block on the access port bus
// Overview of operation
// - table decodes exactly one 4KB block
// - system with several components instantiates this table
// - first-class table reports class 0x1
// - first-class table is read-only, fixed contents
// - second-class table reports class 0x9
// - second-class type/config registers describe table
// - block size field reads zero
// - entry format field zero: 32-bit entries
// - id registers live from offset 0xF00
// - config revision changes with component set
// - component id registers at block + 0xFF0
// - multi-block entry points at id block
// - entries relative, top pointer absolute
// - base pointer: table, sole component, or absent
// - component class in bits 7:4 of cid1
// - entries may point at lower tables
// - component bases aligned up to 64KB
// - first-class list ends with zero word
// - entry at 0xEFC is always final
module dbgrom_table #(
   parameter dbgrom_pkg::dbgrom_class_t TABLE_CLASS = dbgrom_pkg::DBGROM_CLASS1,
   parameter logic [31:0] ENTRY0 = 32'h0000_1003,
   parameter logic [31:0] ENTRY1 = 32'h0001_0003,
   parameter logic [31:0] ENTRY2 = 32'h0002_0003,
   parameter logic [31:0] ENTRY3 = 32'h0000_0000,
   parameter logic [3:0] CONFIG_REVISION = 4'h0
) (
   input wire logic MCLK,
   input wire logic RST_N,
   input wire dbgrom_pkg::dbgrom_req_t REQ,
   output dbgrom_pkg::dbgrom_rsp_t RSP,
   output logic [3:0] LAST_CLASS
);
   // ****************************************************************
   // entry storage
   // ****************************************************************
   logic [31:0] entry_rom [dbgrom_pkg::NUM_ENTRIES];
   // placement, alignment and the absolute top pointer are the integrator's, via ENTRYn
   assign entry_rom[0] = ENTRY0;
   assign entry_rom[1] = ENTRY1;
   assign entry_rom[2] = ENTRY2;
   assign entry_rom[3] = ENTRY3;

   // ****************************************************************
   // decode
   // ****************************************************************
   function automatic logic [31:0] id_byte(input logic [7:0] b);
      id_byte = {24'h00_0000, b};
   endfunction

   logic [3:0] class_val;
   logic [31:0] rd_word;
   logic [11:0] word_addr;
   assign class_val = (TABLE_CLASS == dbgrom_pkg::DBGROM_CLASS9) ?
      dbgrom_pkg::CLASS_TABLE9 : dbgrom_pkg::CLASS_TABLE1;
   assign word_addr = {REQ.addr[11:2], 2'b00};

   // word-aligned read match, byte-lane bits ignored
   function automatic logic rd_at(input dbgrom_pkg::dbgrom_req_t r, input logic [11:0] ofs);
      rd_at = r.rd && ({r.addr[11:2], 2'b00} == ofs);
   endfunction

   always_comb begin
      rd_word = dbgrom_pkg::ZERO_WORD;
      if (word_addr < dbgrom_pkg::ID_REGION_OFS) begin
         // entries beyond the stored ones read as end marker / reserved zero
         if (word_addr[11:2] < 10'(dbgrom_pkg::NUM_ENTRIES)) begin
            rd_word = entry_rom[word_addr[3:2]];
         end else begin
            rd_word = dbgrom_pkg::END_MARKER;
         end
      end else begin
         case (word_addr)
            dbgrom_pkg::DEVCFG_OFS: begin
               if (TABLE_CLASS == dbgrom_pkg::DBGROM_CLASS9) begin
                  rd_word = id_byte({4'h0, dbgrom_pkg::ENTRY_FMT_32});
               end
            end
            dbgrom_pkg::DEVICE_TYPE_REGISTER_OFS: begin
               if (TABLE_CLASS == dbgrom_pkg::DBGROM_CLASS9) begin
                  rd_word = dbgrom_pkg::DEVICE_TYPE_REGISTER_VAL;
               end
            end
            dbgrom_pkg::PID4_OFS:
               rd_word = id_byte({dbgrom_pkg::BLOCK_SIZE_LOG,
                                  dbgrom_pkg::DESIGNER_CONT});
            dbgrom_pkg::PID0_OFS: rd_word = id_byte(dbgrom_pkg::PART_NUM[7:0]);
            dbgrom_pkg::PID1_OFS:
               rd_word = id_byte({dbgrom_pkg::DESIGNER_ID[3:0],
                                  dbgrom_pkg::PART_NUM[11:8]});
            dbgrom_pkg::PID2_OFS:
               rd_word = id_byte({CONFIG_REVISION, 1'b1,
                                  dbgrom_pkg::DESIGNER_ID[6:4]});
            dbgrom_pkg::CID0_OFS: rd_word = id_byte(dbgrom_pkg::CID0_VAL);
            dbgrom_pkg::CID1_OFS:
               rd_word = id_byte({class_val, dbgrom_pkg::CID1_PREAMBLE[3:0]});
            dbgrom_pkg::CID2_OFS: rd_word = id_byte(dbgrom_pkg::CID2_VAL);
            dbgrom_pkg::CID3_OFS: rd_word = id_byte(dbgrom_pkg::CID3_VAL);
            default: rd_word = dbgrom_pkg::ZERO_WORD;
         endcase
      end
   end

   // ****************************************************************
   // response: one cycle, writes dropped without error
   // ****************************************************************
   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         RSP <= '0;
      end else begin
         RSP.ready <= REQ.rd | REQ.wr;
         RSP.err <= 1'b0;
         RSP.rdata <= REQ.rd ? rd_word : dbgrom_pkg::ZERO_WORD;
      end
   end

   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         LAST_CLASS <= 4'h0;
      end else begin
         LAST_CLASS <= class_val;
      end
   end

   // ****************************************************************
   // checks
   // ****************************************************************
   // expected class from the package, independent of the decode path
   localparam logic [3:0] EXP_CLASS = (TABLE_CLASS == dbgrom_pkg::DBGROM_CLASS9) ?
      dbgrom_pkg::CLASS_TABLE9 : dbgrom_pkg::CLASS_TABLE1;

   property p_ready_follows;
      @(posedge MCLK) disable iff (!RST_N) (REQ.rd | REQ.wr) |=> RSP.ready;
   endproperty
   a_ready_follows: assert property (p_ready_follows) else $error("no ready");
   property p_no_err;
      @(posedge MCLK) disable iff (!RST_N) RSP.ready |-> !RSP.err;
   endproperty
   a_no_err: assert property (p_no_err) else $error("error response");
   property p_class;
      @(posedge MCLK) disable iff (!RST_N) (REQ.rd && word_addr == dbgrom_pkg::CID1_OFS)
         |=> RSP.rdata[7:4] == EXP_CLASS;
   endproperty
   a_class: assert property (p_class) else $error("bad class");
   property p_size;
      @(posedge MCLK) disable iff (!RST_N) (REQ.rd && word_addr == dbgrom_pkg::PID4_OFS)
         |=> RSP.rdata[7:4] == 4'h0;
   endproperty
   a_size: assert property (p_size) else $error("size nonzero");
   property p_last;
      @(posedge MCLK) disable iff (!RST_N)
         (REQ.rd && word_addr > dbgrom_pkg::LAST_ENTRY_OFS && word_addr < dbgrom_pkg::PID4_OFS
          && word_addr != dbgrom_pkg::DEVICE_TYPE_REGISTER_OFS && word_addr != dbgrom_pkg::DEVCFG_OFS)
         |=> RSP.rdata == 32'h0000_0000;
   endproperty
   a_last: assert property (p_last) else $error("reserved nonzero");
   property p_stable;
      @(posedge MCLK) disable iff (!RST_N)
         (REQ.rd && $past(REQ.rd) && REQ.addr == $past(REQ.addr)) |=> RSP.rdata == $past(RSP.rdata);
   endproperty
   a_stable: assert property (p_stable) else $error("read changed");
   property p_fmt;
      @(posedge MCLK) disable iff (!RST_N)
         (REQ.rd && word_addr == dbgrom_pkg::DEVCFG_OFS) |=> RSP.rdata[3:0] == 4'h0;
   endproperty
   a_fmt: assert property (p_fmt) else $error("format nonzero");
   property p_wr_quiet;
      @(posedge MCLK) disable iff (!RST_N) (REQ.wr && !REQ.rd) |=> RSP.rdata == 32'h0000_0000;
   endproperty
   a_wr_quiet: assert property (p_wr_quiet) else $error("write data");
   c_read: cover property (@(posedge MCLK) REQ.rd ##1 RSP.ready);
   c_write: cover property (@(posedge MCLK) REQ.wr ##1 RSP.ready);
   c_cid1: cover property (@(posedge MCLK) REQ.rd && word_addr == dbgrom_pkg::CID1_OFS);
   c_final: cover property (@(posedge MCLK) REQ.rd && word_addr == dbgrom_pkg::LAST_ENTRY_OFS);
   c_wr_rd: cover property (@(posedge MCLK) REQ.wr ##1 REQ.rd);

   // ****************************************************************
   // identification words
   // ****************************************************************
   property p_cid0;
      @(posedge MCLK) disable iff (!RST_N)
         rd_at(REQ, dbgrom_pkg::CID0_OFS) |=> RSP.rdata == {24'h00_0000, dbgrom_pkg::CID0_VAL};
   endproperty
   a_cid0: assert property (p_cid0) else $error("component id 0 wrong");

   property p_cid2;
      @(posedge MCLK) disable iff (!RST_N)
         rd_at(REQ, dbgrom_pkg::CID2_OFS) |=> RSP.rdata == {24'h00_0000, dbgrom_pkg::CID2_VAL};
   endproperty
   a_cid2: assert property (p_cid2) else $error("component id 2 wrong");

   property p_cid3;
      @(posedge MCLK) disable iff (!RST_N)
         rd_at(REQ, dbgrom_pkg::CID3_OFS) |=> RSP.rdata == {24'h00_0000, dbgrom_pkg::CID3_VAL};
   endproperty
   a_cid3: assert property (p_cid3) else $error("component id 3 wrong");

   property p_pid0;
      @(posedge MCLK) disable iff (!RST_N)
         rd_at(REQ, dbgrom_pkg::PID0_OFS) |=> RSP.rdata == {24'h00_0000, dbgrom_pkg::PART_NUM[7:0]};
   endproperty
   a_pid0: assert property (p_pid0) else $error("part number low wrong");

   property p_pid1;
      @(posedge MCLK) disable iff (!RST_N)
         rd_at(REQ, dbgrom_pkg::PID1_OFS) |=> RSP.rdata ==
            {24'h00_0000, dbgrom_pkg::DESIGNER_ID[3:0], dbgrom_pkg::PART_NUM[11:8]};
   endproperty
   a_pid1: assert property (p_pid1) else $error("peripheral id 1 wrong");

   // revision must move with the listed set, so it is a parameter, not a constant
   property p_pid2;
      @(posedge MCLK) disable iff (!RST_N)
         rd_at(REQ, dbgrom_pkg::PID2_OFS) |=> RSP.rdata[7:3] == {CONFIG_REVISION, 1'b1};
   endproperty
   a_pid2: assert property (p_pid2) else $error("revision field wrong");

   property p_pid3;
      @(posedge MCLK) disable iff (!RST_N)
         rd_at(REQ, dbgrom_pkg::PID3_OFS) |=> RSP.rdata == dbgrom_pkg::ZERO_WORD;
   endproperty
   a_pid3: assert property (p_pid3) else $error("peripheral id 3 nonzero");

   property p_pid_hi;
      @(posedge MCLK) disable iff (!RST_N)
         (rd_at(REQ, dbgrom_pkg::PID5_OFS) || rd_at(REQ, dbgrom_pkg::PID6_OFS)
          || rd_at(REQ, dbgrom_pkg::PID7_OFS)) |=> RSP.rdata == dbgrom_pkg::ZERO_WORD;
   endproperty
   a_pid_hi: assert property (p_pid_hi) else $error("upper peripheral ids nonzero");

   property p_size_cont;
      @(posedge MCLK) disable iff (!RST_N)
         rd_at(REQ, dbgrom_pkg::PID4_OFS) |=> RSP.rdata ==
            {24'h00_0000, dbgrom_pkg::BLOCK_SIZE_LOG, dbgrom_pkg::DESIGNER_CONT};
   endproperty
   a_size_cont: assert property (p_size_cont) else $error("peripheral id 4 wrong");

   property p_class_full;
      @(posedge MCLK) disable iff (!RST_N)
         rd_at(REQ, dbgrom_pkg::CID1_OFS) |=> RSP.rdata == {24'h00_0000, EXP_CLASS, 4'h0};
   endproperty
   a_class_full: assert property (p_class_full) else $error("class word wrong");

   property p_cid1_pre;
      @(posedge MCLK) disable iff (!RST_N)
         rd_at(REQ, dbgrom_pkg::CID1_OFS) |=> RSP.rdata[3:0] == dbgrom_pkg::CID1_PREAMBLE[3:0];
   endproperty
   a_cid1_pre: assert property (p_cid1_pre) else $error("class low nibble wrong");

   property p_id_upper;
      @(posedge MCLK) disable iff (!RST_N)
         (REQ.rd && word_addr >= dbgrom_pkg::ID_REGION_OFS) |=> RSP.rdata[31:8] == 24'h00_0000;
   endproperty
   a_id_upper: assert property (p_id_upper) else $error("id upper bits set");

   property p_id_reserved;
      @(posedge MCLK) disable iff (!RST_N)
         (REQ.rd && word_addr >= dbgrom_pkg::ID_REGION_OFS
          && word_addr < dbgrom_pkg::DEVCFG_OFS)
         |=> RSP.rdata == dbgrom_pkg::ZERO_WORD;
   endproperty
   a_id_reserved: assert property (p_id_reserved) else $error("id region gap nonzero");

   property p_devcfg;
      @(posedge MCLK) disable iff (!RST_N)
         rd_at(REQ, dbgrom_pkg::DEVCFG_OFS) |=> RSP.rdata ==
            ((TABLE_CLASS == dbgrom_pkg::DBGROM_CLASS9) ?
             {28'h000_0000, dbgrom_pkg::ENTRY_FMT_32} : dbgrom_pkg::ZERO_WORD);
   endproperty
   a_devcfg: assert property (p_devcfg) else $error("config word wrong");

   property p_device_type_register;
      @(posedge MCLK) disable iff (!RST_N)
         rd_at(REQ, dbgrom_pkg::DEVICE_TYPE_REGISTER_OFS) |=> RSP.rdata ==
            ((TABLE_CLASS == dbgrom_pkg::DBGROM_CLASS9) ?
             dbgrom_pkg::DEVICE_TYPE_REGISTER_VAL : dbgrom_pkg::ZERO_WORD);
   endproperty
   a_device_type_register: assert property (p_device_type_register) else $error("type word wrong");

   // ****************************************************************
   // entries and bus behaviour
   // ****************************************************************
   for (genvar i = 0; i < dbgrom_pkg::NUM_ENTRIES; i++) begin : g_entry_chk
      property p_entry;
         @(posedge MCLK) disable iff (!RST_N)
            rd_at(REQ, 12'(4 * i)) |=> RSP.rdata == entry_rom[i];
      endproperty
      a_entry: assert property (p_entry) else $error("entry word wrong");
   end

   // a table with fewer stored words reads as terminated right after them
   property p_end_marker;
      @(posedge MCLK) disable iff (!RST_N)
         (REQ.rd && word_addr >= 12'(4 * dbgrom_pkg::NUM_ENTRIES)
          && word_addr <= dbgrom_pkg::LAST_ENTRY_OFS)
         |=> RSP.rdata == dbgrom_pkg::END_MARKER;
   endproperty
   a_end_marker: assert property (p_end_marker) else $error("missing end marker");

   property p_final_entry;
      @(posedge MCLK) disable iff (!RST_N)
         rd_at(REQ, dbgrom_pkg::LAST_ENTRY_OFS) |=> RSP.rdata == dbgrom_pkg::END_MARKER;
   endproperty
   a_final_entry: assert property (p_final_entry) else $error("last entry wrong");

   property p_ready_cause;
      @(posedge MCLK) disable iff (!RST_N) RSP.ready |-> $past(REQ.rd | REQ.wr);
   endproperty
   a_ready_cause: assert property (p_ready_cause) else $error("stray ready");

   property p_ready_idle;
      @(posedge MCLK) disable iff (!RST_N) !(REQ.rd || REQ.wr) |=> !RSP.ready;
   endproperty
   a_ready_idle: assert property (p_ready_idle) else $error("ready without request");

   property p_rdata_idle;
      @(posedge MCLK) disable iff (!RST_N) !REQ.rd |=> RSP.rdata == dbgrom_pkg::ZERO_WORD;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("data without read");

   property p_write_done;
      @(posedge MCLK) disable iff (!RST_N) REQ.wr |=> RSP.ready && !RSP.err;
   endproperty
   a_write_done: assert property (p_write_done) else $error("write not completed");

   property p_reset_quiet;
      @(posedge MCLK) !RST_N |=> (RSP == '0) && (LAST_CLASS == 4'h0);
   endproperty
   a_reset_quiet: assert property (p_reset_quiet) else $error("outputs not cleared");

   property p_class_steady;
      @(posedge MCLK) disable iff (!RST_N) $past(RST_N) |-> LAST_CLASS == EXP_CLASS;
   endproperty
   a_class_steady: assert property (p_class_steady) else $error("class output wrong");

   // byte-lane bits must not select a different word
   property p_bytelane;
      @(posedge MCLK) disable iff (!RST_N)
         (REQ.rd && $past(REQ.rd) && REQ.addr[11:2] == $past(REQ.addr[11:2]))
         |=> RSP.rdata == $past(RSP.rdata);
   endproperty
   a_bytelane: assert property (p_bytelane) else $error("byte lane changed data");
endmodule

// >>> hw/dbgrom_pkg.sv
// package: constants and types for the debug rom table block
package dbgrom_pkg;
   // ****************************************************************
   // address map
   // ****************************************************************
   localparam int ADDR_W = 12;
   localparam logic [11:0] BLOCK_BYTES_M1 = 12'h0_FFF;
   localparam logic [11:0] LAST_ENTRY_OFS = 12'h0_EFC;
   localparam logic [11:0] ID_REGION_OFS = 12'h0_F00;
   localparam logic [11:0] DEVCFG_OFS = 12'h0_FC8;
   localparam logic [11:0] DEVICE_TYPE_REGISTER_OFS = 12'h0_FCC;
   localparam logic [11:0] PID4_OFS = 12'h0_FD0;
   localparam logic [11:0] PID5_OFS = 12'h0_FD4;
   localparam logic [11:0] PID6_OFS = 12'h0_FD8;
   localparam logic [11:0] PID7_OFS = 12'h0_FDC;
   localparam logic [11:0] PID0_OFS = 12'h0_FE0;
   localparam logic [11:0] PID1_OFS = 12'h0_FE4;
   localparam logic [11:0] PID2_OFS = 12'h0_FE8;
   localparam logic [11:0] PID3_OFS = 12'h0_FEC;
   localparam logic [11:0] CID0_OFS = 12'h0_FF0;
   localparam logic [11:0] CID1_OFS = 12'h0_FF4;
   localparam logic [11:0] CID2_OFS = 12'h0_FF8;
   localparam logic [11:0] CID3_OFS = 12'h0_FFC;
   // ****************************************************************
   // fields and values
   // ****************************************************************
   localparam int NUM_ENTRIES = 4;
   localparam int ENTRY_SHIFT = 12;
   localparam int CLASS_LSB = 4;
   localparam int SIZE_LSB = 4;
   localparam int FORMAT_LSB = 0;
   localparam logic [3:0] CLASS_TABLE1 = 4'h1;
   localparam logic [3:0] CLASS_TABLE9 = 4'h9;
   localparam logic [3:0] BLOCK_SIZE_LOG = 4'h0;
   localparam logic [3:0] ENTRY_FMT_32 = 4'h0;
   localparam logic [7:0] CID0_VAL = 8'h0D;
   localparam logic [7:0] CID2_VAL = 8'h05;
   localparam logic [7:0] CID3_VAL = 8'hB1;
   localparam logic [7:0] CID1_PREAMBLE = 8'h00;
   localparam logic [31:0] END_MARKER = 32'h0000_0000;
   localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
   // arbitrary identity values, no real maker or part
   localparam logic [11:0] PART_NUM = 12'h0_123;
   localparam logic [6:0] DESIGNER_ID = 7'h05;
   localparam logic [3:0] DESIGNER_CONT = 4'h0;
   localparam logic [3:0] BASE_REVISION = 4'h0;
   localparam logic [31:0] DEVICE_TYPE_REGISTER_VAL = 32'h0000_0000;
   // ****************************************************************
   // types
   // ****************************************************************
   typedef enum logic {DBGROM_CLASS1, DBGROM_CLASS9} dbgrom_class_t;
   typedef struct packed {
      logic [11:0] addr;
      logic        rd;
      logic        wr;
      logic [31:0] wdata;
   } dbgrom_req_t;
   typedef struct packed {
      logic        ready;
      logic        err;
      logic [31:0] rdata;
   } dbgrom_rsp_t;
endpackage

// >>> verif/dbgrom_dbg_model.sv
// debugger-side requester model on the access port bus
module dbgrom_dbg_model (
   input wire logic mclk,
   output dbgrom_pkg::dbgrom_req_t req
);
   timeunit 1ns;
   timeprecision 1ps;
   initial req = '0;
   // ****************************************************************
   // bus cycles
   // ****************************************************************
   // one access per call; consecutive calls give one access per cycle
   task automatic acc(input logic [11:0] a, input logic w);
      @(negedge mclk);
      req.addr <= a;
      req.rd <= !w;
      req.wr <= w;
      req.wdata <= $urandom;
   endtask
   // block address of an entry's target; the block-size field plays no part
   function automatic logic [31:0] comp_addr(input logic [31:0] base, input logic [31:0] ent);
      comp_addr = base + {ent[31:12], 12'h000};
   endfunction
   // released bus shows junk, never the last request's values
   task automatic idle();
      @(negedge mclk);
      req <= {~req.addr, 2'b00, 32'($urandom)};
   endtask
endmodule

// >>> verif/debug_rom_table_discovery_tb_top.sv
// self-checking bench for the rom table, one table of each class
module debug_rom_table_discovery_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   dbgrom_pkg::dbgrom_req_t req;
   dbgrom_pkg::dbgrom_rsp_t rsp1;
   dbgrom_pkg::dbgrom_rsp_t rsp9;
   logic [3:0] cls1;
   logic [3:0] cls9;
   logic [63:0] exp_q[$];
   logic [63:0] e;
   int failures = 0;
   int n_compared = 0;
   localparam logic [7:0] ID1 [14] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h23,
      8'h51, 8'h08, 8'h00, 8'h0D, 8'h10, 8'h05, 8'hB1};
   localparam logic [31:0] ENT [5] = '{32'h0000_1003, 32'h0001_0003, 32'h0002_0003,
      32'h0000_0000, 32'h0000_0000};
   always #4 mclk = ~mclk;
   dbgrom_dbg_model i_dbgrom_dbg_model (.mclk(mclk), .req(req));
   dbgrom_table i_dbgrom_table (.MCLK(mclk), .RST_N(rst_n), .REQ(req), .RSP(rsp1),
      .LAST_CLASS(cls1));
   // second table differs in class and configuration revision only
   dbgrom_table #(.TABLE_CLASS(dbgrom_pkg::DBGROM_CLASS9), .CONFIG_REVISION(4'h3))
      i_dbgrom_table_c9 (.MCLK(mclk), .RST_N(rst_n), .REQ(req), .RSP(rsp9),
      .LAST_CLASS(cls9));
   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic acc(input logic [11:0] a, input logic w, input logic [31:0] e1,
      input logic [31:0] e9);
      i_dbgrom_dbg_model.acc(a, w);
      exp_q.push_back({e9, e1});
   endtask
   // ****************************************************************
   // response monitor
   // ****************************************************************
   // an unexpected response pops all ones, so it cannot match
   always @(negedge mclk) begin
      if (rsp1.ready === 1'b1) begin
         e = (exp_q.size() > 0) ? exp_q.pop_front() : ~64'h0;
         check(rsp1.rdata, e[31:0], "class1 data");
         check(rsp9.rdata, e[63:32], "class9 data");
         check({29'h0, rsp1.err, rsp9.err, rsp9.ready}, 32'h1, "response");
         check({24'h0, cls1, cls9}, 32'h19, "class");
      end
   end
   task automatic final_report();
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // ****************************************************************
   // main sequence
   // ****************************************************************
   initial begin
      logic [31:0] v;
      void'($urandom(32'hf5b9275c));
      repeat (8) @(negedge mclk);
      check({27'h0, rsp1.ready, cls1}, 32'h0, "reset");
      rst_n <= 1'b1;
      for (int i = 0; i < 14; i++) begin
         v = {24'h0, ID1[i]};
         acc(12'hFC8 + 12'(4 * i), 1'b0, v, i == 8 ? v | 32'h30 : i == 11 ? 32'h90 : v);
      end
      $display("test id registers done");
      for (int i = 0; i < 5; i++) begin
         acc(12'(4 * i), 1'b0, ENT[i], ENT[i]);
      end
      check(i_dbgrom_dbg_model.comp_addr(32'h8000_0000, ENT[1]), 32'h8001_0000, "address");
      acc(12'hEFC, 1'b0, 32'h0, 32'h0);
      $display("test entries done");
      // reserved space, stray byte-lane bits included
      for (int i = 0; i < 16; i++) begin
         acc(12'h010 + 12'($urandom % 1006) * 4 + 12'($urandom % 4), 1'b0, 0, 0);
      end
      $display("test reserved done");
      acc(12'h000, 1'b1, 0, 0);
      acc(12'hFF4, 1'b1, 0, 0);
      acc(12'h000, 1'b0, ENT[0], ENT[0]);
      acc(12'hFF4, 1'b0, 32'h10, 32'h90);
      i_dbgrom_dbg_model.idle();
      for (int k = 0; k < 20 && exp_q.size() > 0; k++) @(negedge mclk);
      if (exp_q.size() > 0) begin
         failures++;
         $display("[FAIL] %0t responses missing", $time);
      end
      repeat (3) @(negedge mclk);
      $display("test writes done");
      final_report();
   end
endmodule
